// file: rtl/dsf_pkg.sv
package dsf_pkg;

    localparam int DSF_AW = 12;
    localparam int DSF_DW = 32;

    // Register byte addresses
    localparam logic [DSF_AW-1:0] DSF_ADDR_CRC_LOW = 12'h50D;
    localparam logic [DSF_AW-1:0] DSF_ADDR_DIAG = 12'h526;
    localparam logic [DSF_AW-1:0] DSF_ADDR_CTRL = 12'h600;
    localparam logic [DSF_AW-1:0] DSF_ADDR_IRQ_STAT = 12'h604;
    localparam logic [DSF_AW-1:0] DSF_ADDR_IRQ_MASK = 12'h608;

    localparam logic [7:0] DSF_CRC_RESET = 8'hF3;
    localparam logic [4:0] DSF_DIAG_RESET = 5'h00;

    // Protector mode field codes
    localparam logic [1:0] DSF_MODE_SCAN = 2'h1;
    localparam logic [1:0] DSF_MODE_SELFTEST = 2'h2;

    // Control register field positions
    localparam int DSF_CTRL_TEMP_START = 0;
    localparam int DSF_CTRL_TEMP_MODE = 1;
    localparam int DSF_CTRL_VOLT_START = 3;
    localparam int DSF_CTRL_VOLT_MODE = 4;
    localparam int DSF_CTRL_SUPPLY_START = 6;

    localparam logic [DSF_DW-1:0] DSF_UNMAPPED = 32'h0000_0000;

    // Diagnostic flag layout, bit 4 down to bit 0
    typedef struct packed {
        logic temp_scan_done;
        logic volt_scan_done;
        logic temp_selftest_done;
        logic volt_selftest_done;
        logic supply_selftest_done;
    } dsf_flags_t;

    typedef struct packed {
        logic [DSF_AW-1:0] address;
        logic read;
        logic write;
        logic [DSF_DW-1:0] writedata;
    } dsf_req_t;

endpackage : dsf_pkg

// file: rtl/dsf_done_flag.sv
`timescale 1ns/1ps
module dsf_done_flag
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic clr,
    input wire logic set,
    output logic flag
);
    import dsf_pkg::*;

    logic next_flag;

    // A completion in the clearing cycle wins
    always_comb
    begin
        next_flag = flag;
        if (clr)
        begin
            next_flag = 1'b0;
        end
        if (set)
        begin
            next_flag = 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            flag <= 1'b0;
        end
        else
        begin
            flag <= next_flag;
        end
    end

    a_flag_set_cause: assert property (@(posedge mclk) disable iff (rst)
        !$past(flag) && flag |-> $past(set))
        else $error("flag rose without completion");

endmodule : dsf_done_flag

// file: rtl/dsf_status.sv
`timescale 1ns/1ps
module dsf_status
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [dsf_pkg::DSF_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [dsf_pkg::DSF_DW-1:0] avs_writedata,
    output logic [dsf_pkg::DSF_DW-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [7:0] crc_value,
    input wire logic crc_valid,
    input wire dsf_pkg::dsf_flags_t run_complete,
    output logic temp_protector_start,
    output logic [1:0] temp_protector_mode,
    output logic volt_protector_start,
    output logic [1:0] volt_protector_mode,
    output logic supply_selftest_start,
    output logic irq
);
    import dsf_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Bus slave: one wait cycle, answer on the second edge
    logic busy;
    logic next_busy;
    dsf_req_t req;
    logic [DSF_DW-1:0] next_readdata;
    logic next_waitrequest;
    logic [7:0] crc_low;
    logic [7:0] next_crc_low;
    dsf_flags_t flags;
    dsf_flags_t clr;
    dsf_flags_t irq_stat;
    dsf_flags_t next_irq_stat;
    dsf_flags_t irq_mask;
    dsf_flags_t next_irq_mask;
    dsf_flags_t prev_flags;
    logic wr_ctrl;
    logic next_irq;
    logic next_tstart;
    logic next_vstart;
    logic next_sstart;
    logic [1:0] next_tmode;
    logic [1:0] next_vmode;

    always_comb
    begin
        req.address = avs_address;
        req.read = avs_read;
        req.write = avs_write;
        req.writedata = avs_writedata;
    end

    always_comb
    begin
        next_busy = 1'b0;
        next_waitrequest = 1'b1;
        next_readdata = avs_readdata;
        if ((req.read || req.write) && !busy)
        begin
            next_busy = 1'b1;
            next_waitrequest = 1'b0;
            next_readdata = DSF_UNMAPPED;
            if (req.read)
            begin
                unique case (req.address)
                    DSF_ADDR_CRC_LOW:
                        next_readdata = {24'h000000, crc_low};
                    DSF_ADDR_DIAG:
                        next_readdata = {27'h0000000, flags};
                    DSF_ADDR_IRQ_STAT:
                        next_readdata = {27'h0000000, irq_stat};
                    DSF_ADDR_IRQ_MASK:
                        next_readdata = {27'h0000000, irq_mask};
                    default:
                        next_readdata = DSF_UNMAPPED;
                endcase
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            busy <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= DSF_UNMAPPED;
        end
        else
        begin
            busy <= next_busy;
            avs_waitrequest <= next_waitrequest;
            avs_readdata <= next_readdata;
        end
    end

    // A write takes effect in the cycle waitrequest is low
    assign wr_ctrl = req.write && busy && !avs_waitrequest;

    ////////////////////////////////////////////////////////////////////////
    // Device CRC result byte
    always_comb
    begin
        next_crc_low = crc_low;
        if (crc_valid)
        begin
            next_crc_low = crc_value;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            crc_low <= DSF_CRC_RESET;
        end
        else
        begin
            crc_low <= next_crc_low;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Start strobes and mode fields
    always_comb
    begin
        next_tstart = 1'b0;
        next_vstart = 1'b0;
        next_sstart = 1'b0;
        next_tmode = temp_protector_mode;
        next_vmode = volt_protector_mode;
        if (wr_ctrl && req.address == DSF_ADDR_CTRL)
        begin
            next_tstart = req.writedata[DSF_CTRL_TEMP_START];
            next_vstart = req.writedata[DSF_CTRL_VOLT_START];
            next_sstart = req.writedata[DSF_CTRL_SUPPLY_START];
            next_tmode = req.writedata[DSF_CTRL_TEMP_MODE +: 2];
            next_vmode = req.writedata[DSF_CTRL_VOLT_MODE +: 2];
        end
    end

    always_comb
    begin
        clr = '0;
        clr.temp_scan_done = next_tstart && next_tmode == DSF_MODE_SCAN;
        clr.volt_scan_done = next_vstart && next_vmode == DSF_MODE_SCAN;
        clr.volt_selftest_done =
            next_vstart && next_vmode == DSF_MODE_SELFTEST;
        clr.supply_selftest_done = next_sstart;
        clr.temp_selftest_done =
            next_tstart && next_tmode == DSF_MODE_SELFTEST;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            temp_protector_start <= 1'b0;
            volt_protector_start <= 1'b0;
            supply_selftest_start <= 1'b0;
            temp_protector_mode <= 2'h0;
            volt_protector_mode <= 2'h0;
        end
        else
        begin
            temp_protector_start <= next_tstart;
            volt_protector_start <= next_vstart;
            supply_selftest_start <= next_sstart;
            temp_protector_mode <= next_tmode;
            volt_protector_mode <= next_vmode;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Completion flags
    for (genvar i = 0; i < $bits(dsf_flags_t); i++)
    begin : g_flag
        dsf_done_flag u_flag
        (
            .mclk(mclk),
            .rst(rst),
            .clr(clr[i]),
            .set(run_complete[i]),
            .flag(flags[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt: rising flag sets a sticky bit, write one clears
    always_comb
    begin
        next_irq_stat = irq_stat;
        next_irq_mask = irq_mask;
        if (wr_ctrl && req.address == DSF_ADDR_IRQ_STAT)
        begin
            next_irq_stat = irq_stat & ~dsf_flags_t'(req.writedata[4:0]);
        end
        if (wr_ctrl && req.address == DSF_ADDR_IRQ_MASK)
        begin
            next_irq_mask = dsf_flags_t'(req.writedata[4:0]);
        end
        next_irq_stat = next_irq_stat | (flags & ~prev_flags);
        next_irq = |(next_irq_stat & next_irq_mask);
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            irq_stat <= DSF_DIAG_RESET;
            irq_mask <= DSF_DIAG_RESET;
            prev_flags <= DSF_DIAG_RESET;
            irq <= 1'b0;
        end
        else
        begin
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            prev_flags <= flags;
            irq <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_crc_reset_value: assert property (@(posedge mclk)
        $fell(rst) |-> crc_low == DSF_CRC_RESET)
        else $error("crc byte wrong after reset");
    a_crc_tracks_input: assert property (@(posedge mclk) disable iff (rst)
        crc_valid |=> crc_low == $past(crc_value))
        else $error("crc byte not loaded");
    a_temp_scan_clear: assert property (@(posedge mclk) disable iff (rst)
        clr.temp_scan_done && !run_complete.temp_scan_done
        |=> !flags.temp_scan_done)
        else $error("temp scan flag not cleared");
    a_volt_scan_clear: assert property (@(posedge mclk) disable iff (rst)
        clr.volt_scan_done && !run_complete.volt_scan_done
        |=> !flags.volt_scan_done)
        else $error("volt scan flag not cleared");
    a_volt_test_clear: assert property (@(posedge mclk) disable iff (rst)
        clr.volt_selftest_done && !run_complete.volt_selftest_done
        |=> !flags.volt_selftest_done)
        else $error("volt selftest flag not cleared");
    a_supply_test_clear: assert property (@(posedge mclk) disable iff (rst)
        clr.supply_selftest_done && !run_complete.supply_selftest_done
        |=> !flags.supply_selftest_done)
        else $error("supply selftest flag not cleared");
    a_temp_test_clear: assert property (@(posedge mclk) disable iff (rst)
        clr.temp_selftest_done && !run_complete.temp_selftest_done
        |=> !flags.temp_selftest_done)
        else $error("temp selftest flag not cleared");
    a_flag_set_wins: assert property (@(posedge mclk) disable iff (rst)
        run_complete.volt_scan_done |=> flags.volt_scan_done)
        else $error("completion lost");
    a_bus_answer_one: assert property (@(posedge mclk) disable iff (rst)
        (avs_read || avs_write) && avs_waitrequest && !busy
        |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer timing wrong");

    c_temp_scan: cover property (@(posedge mclk) disable iff (rst)
        clr.temp_scan_done ##[1:50] flags.temp_scan_done);
    c_volt_test: cover property (@(posedge mclk) disable iff (rst)
        clr.volt_selftest_done ##[1:50] flags.volt_selftest_done);
    c_irq_raised: cover property (@(posedge mclk) disable iff (rst)
        $rose(irq));

endmodule : dsf_status

// file: test/dsf_status_tb.sv
`timescale 1ns/1ps
module dsf_status_tb;
    import dsf_pkg::*;

    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [DSF_AW-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [DSF_DW-1:0] avs_writedata = '0;
    logic [DSF_DW-1:0] avs_readdata;
    logic avs_waitrequest;
    logic [7:0] crc_value = 8'h00;
    logic crc_valid = 1'b0;
    dsf_flags_t run_complete = '0;
    logic temp_protector_start;
    logic [1:0] temp_protector_mode;
    logic volt_protector_start;
    logic [1:0] volt_protector_mode;
    logic supply_selftest_start;
    logic irq;
    int mismatches = 0;
    int compares = 0;
    logic [DSF_DW-1:0] rd;
    logic [6:0] ctrl_tab [6] = '{7'h02, 7'h03, 7'h18, 7'h05, 7'h28, 7'h40};
    logic [4:0] diag_tab [6] = '{5'h1F, 5'h0F, 5'h07, 5'h03, 5'h01, 5'h00};

    always #50 mclk = ~mclk;

    dsf_status dut
    (
        .mclk(mclk),
        .rst(rst),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .crc_value(crc_value),
        .crc_valid(crc_valid),
        .run_complete(run_complete),
        .temp_protector_start(temp_protector_start),
        .temp_protector_mode(temp_protector_mode),
        .volt_protector_start(volt_protector_start),
        .volt_protector_mode(volt_protector_mode),
        .supply_selftest_start(supply_selftest_start),
        .irq(irq)
    );

    ////////////////////////////////////////////////////////////////////////
    task complete_run;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run

    task check(input logic [DSF_DW-1:0] seen, input logic [DSF_DW-1:0] exp);
        compares++;
        if (seen !== exp)
        begin
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
            mismatches++;
        end
    endtask : check

    // Holds the request until waitrequest is sampled low
    task bus_cycle(input logic [DSF_AW-1:0] a, input logic wr,
                   input logic [DSF_DW-1:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50)
        begin
            mismatches++;
            complete_run();
        end
    endtask : bus_cycle

    task bus_read(input logic [DSF_AW-1:0] a);
        bus_cycle(a, 1'b0, '0);
    endtask : bus_read

    task bus_write(input logic [DSF_AW-1:0] a, input logic [DSF_DW-1:0] d);
        bus_cycle(a, 1'b1, d);
    endtask : bus_write

    task pulse_done(input int i);
        @(posedge mclk);
        run_complete <= dsf_flags_t'(5'h01 << i);
        @(posedge mclk);
        run_complete <= '0;
    endtask : pulse_done

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        complete_run();
    end

    initial
    begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        bus_read(DSF_ADDR_CRC_LOW);
        check(rd, 32'h0000_00F3);
        bus_read(DSF_ADDR_DIAG);
        check(rd, 32'h0000_0000);
        // Device CRC byte loads, and a bus write cannot alter it
        @(posedge mclk);
        crc_value <= 8'hA5;
        crc_valid <= 1'b1;
        @(posedge mclk);
        crc_valid <= 1'b0;
        bus_write(DSF_ADDR_CRC_LOW, 32'h0000_005A);
        bus_read(DSF_ADDR_CRC_LOW);
        check(rd, 32'h0000_00A5);
        bus_read(12'h123);
        check(rd, DSF_UNMAPPED);
        // Every run completes; interrupt stays low while masked
        for (int i = 0; i < 5; i++)
            pulse_done(i);
        repeat (3) @(posedge mclk);
        #1;
        check({31'h0, irq}, 32'h0);
        bus_read(DSF_ADDR_IRQ_STAT);
        check(rd, 32'h0000_001F);
        bus_write(DSF_ADDR_IRQ_MASK, 32'h0000_0001);
        repeat (3) @(posedge mclk);
        #1;
        check({31'h0, irq}, 32'h1);
        bus_write(DSF_ADDR_IRQ_STAT, 32'h0000_0001);
        repeat (3) @(posedge mclk);
        #1;
        check({31'h0, irq}, 32'h0);
        bus_read(DSF_ADDR_IRQ_STAT);
        check(rd, 32'h0000_001E);
        // Each start with its mode clears only its own flag
        for (int i = 0; i < 6; i++)
        begin
            bus_write(DSF_ADDR_CTRL, {25'h0, ctrl_tab[i]});
            // Start pulses stand only for the cycle after the answer
            #1;
            check({supply_selftest_start, volt_protector_mode,
                   volt_protector_start, temp_protector_mode,
                   temp_protector_start}, ctrl_tab[i]);
            bus_read(DSF_ADDR_DIAG);
            check(rd, {27'h0, diag_tab[i]});
        end
        // A finished run sets its flag again
        pulse_done(4);
        bus_read(DSF_ADDR_DIAG);
        check(rd, 32'h0000_0010);
        complete_run();
    end

endmodule : dsf_status_tb
